// >>> hw/ued_decode.sv
// ued_decode.sv: decode end; applies the unused-encoding policy and requests faults
// assumes: the issuer places group and slot marked instructions legally
// Function
// - ignored encodings run as no-operation, no fault
// - reserved encodings always fault, predicate regardless
// - predicated-reserved faults if selected predicate is one
// - nonzero constant-zero field may raise fault
// - no constant-zero fault while predicate reads zero, unless the zero field covers bits 5:0
// - zero field in bits 5:0 may ignore predicate
// - ignored field contents never change decode
// - group-leading instruction placed first in group
// - group-ending instruction placed last in group
// - slot-restricted instruction only in slot 2
// - qualifying predicate field names governing predicate
`timescale 1ns/10ps
`default_nettype none
`include "ued_regs.svh"
module ued_decode
  import ued_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // link
  ued_link_if.decoder lnk,
  // execution side
  output logic exe_valid_ff,
  output ued_action_t exe_action_ff,
  output logic [`UED_INSN_W-1:0] exe_insn_ff,
  // exception side
  output logic exc_fault_ff,
  output logic [`UED_SLOT_W-1:0] exc_slot_ff,
  output logic exc_place_err_ff
);
  logic nxt_valid, nxt_fault, nxt_perr;
  ued_action_t nxt_action;
  logic [`UED_INSN_W-1:0] nxt_insn;
  logic [`UED_SLOT_W-1:0] nxt_slot;

  function automatic logic pred_of(input logic [`UED_INSN_W-1:0] insn,
                                   input logic [`UED_NPRED-1:0] prf);
    logic [`UED_QP_W-1:0] qp;
    qp = insn[`UED_QP_HI:`UED_QP_LO];
    // predicate 0 is hard-wired true
    pred_of = (qp == `UED_PRED_P0) ? 1'b1 : prf[qp];
  endfunction : pred_of

  always_comb
  begin
    logic pv;
    logic zbad;
    logic zlow;
    pv = pred_of(lnk.issue_insn, lnk.predicate_register_file);
    zbad = |(lnk.issue_insn & lnk.issue_zero_mask);
    // zero field covering the predicate bits: predicate not consulted
    zlow = |lnk.issue_zero_mask[`UED_QP_HI:`UED_QP_LO];
    nxt_valid = lnk.issue_valid;
    nxt_action = UED_ACT_NONE;
    nxt_insn = lnk.issue_insn & ~lnk.issue_ign_mask;
    nxt_slot = lnk.issue_slot;
    nxt_fault = 1'b0;
    nxt_perr = 1'b0;
    if (lnk.issue_valid)
    begin
      case (lnk.issue_class)
        UED_CLS_IGNORED: nxt_action = UED_ACT_NOP;
        UED_CLS_RESERVED: nxt_action = UED_ACT_FAULT;
        UED_CLS_RSV_IF_PRED: nxt_action = pv ? UED_ACT_FAULT : UED_ACT_NOP;
        UED_CLS_DEFINED: nxt_action = UED_ACT_EXEC;
        default: nxt_action = UED_ACT_FAULT;
      endcase
      // qualified-off zero-field errors stay silent unless the zero field covers bits 5:0
      if (lnk.issue_class == UED_CLS_DEFINED && zbad)
      begin
        if (zlow || pv)
          nxt_action = UED_ACT_FAULT;
        else
          nxt_action = UED_ACT_NOP;
      end
      // placement slips flagged only, the issuer owns placement
      nxt_perr = (lnk.issue_lead && !lnk.issue_first_in_group)
                 || (lnk.issue_end && !lnk.issue_last_in_group)
                 || (lnk.issue_slot_only2 && lnk.issue_slot != `UED_SLOT_RESTRICT);
      nxt_fault = (nxt_action == UED_ACT_FAULT);
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      exe_valid_ff <= 1'b0;
      exe_action_ff <= UED_ACT_NONE;
      exe_insn_ff <= `UED_ZERO_FIELD;
      exc_fault_ff <= 1'b0;
      exc_slot_ff <= '0;
      exc_place_err_ff <= 1'b0;
    end
    else
    begin
      exe_valid_ff <= nxt_valid;
      exe_action_ff <= nxt_action;
      exe_insn_ff <= nxt_insn;
      exc_fault_ff <= nxt_fault;
      exc_slot_ff <= nxt_slot;
      exc_place_err_ff <= nxt_perr;
    end
  end

  assign lnk.dec_valid = exe_valid_ff;
  assign lnk.dec_action = exe_action_ff;
  assign lnk.dec_insn = exe_insn_ff;
  assign lnk.fault_req = exc_fault_ff;
  assign lnk.fault_slot = exc_slot_ff;
endmodule : ued_decode
`default_nettype wire

// >>> hw/ued_issue.sv
// ued_issue.sv: issue end; places instructions into groups and bundle slots
// assumes: user side offers one instruction a cycle with its class and placement marks
`timescale 1ns/10ps
`default_nettype none
`include "ued_regs.svh"
module ued_issue
  import ued_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // user side
  input wire logic usr_valid,
  input wire logic [`UED_INSN_W-1:0] usr_insn,
  input wire logic [`UED_INSN_W-1:0] usr_zero_mask,
  input wire logic [`UED_INSN_W-1:0] usr_ign_mask,
  input wire ued_class_t usr_class,
  input wire logic usr_lead,
  input wire logic usr_end,
  input wire logic usr_slot_only2,
  input wire logic [`UED_NPRED-1:0] usr_preds,
  output logic usr_placed_ff,
  output logic usr_fault_ff,
  output logic [`UED_SLOT_W-1:0] usr_fault_slot_ff,
  // link
  ued_link_if.issuer lnk
);
  logic [`UED_SLOT_W-1:0] slot_ff, nxt_slot;
  logic first_ff, nxt_first;
  logic vld_ff, nxt_vld;
  logic [`UED_INSN_W-1:0] insn_ff, nxt_insn, zm_ff, nxt_zm, im_ff, nxt_im;
  ued_class_t cls_ff, nxt_cls;
  logic lead_ff, nxt_lead, end_ff, nxt_end, only2_ff, nxt_only2, fig_ff, nxt_fig;
  logic placed_nxt_o;
  logic [`UED_NPRED-1:0] pr_ff, nxt_pr;

  always_comb
  begin
    nxt_slot = slot_ff;
    nxt_first = first_ff;
    nxt_vld = 1'b0;
    nxt_insn = insn_ff;
    nxt_zm = zm_ff;
    nxt_im = im_ff;
    nxt_cls = cls_ff;
    nxt_lead = 1'b0;
    nxt_end = 1'b0;
    nxt_only2 = 1'b0;
    nxt_fig = 1'b0;
    nxt_pr = usr_preds;
    placed_nxt_o = 1'b0;
    if (usr_valid)
    begin
      nxt_vld = 1'b1;
      nxt_insn = usr_insn;
      // unassigned zero and ignored bits are driven as zero
      nxt_zm = usr_zero_mask;
      nxt_im = usr_ign_mask;
      nxt_insn = usr_insn & ~(usr_ign_mask | usr_zero_mask);
      nxt_cls = usr_class;
      nxt_lead = usr_lead;
      nxt_end = usr_end;
      nxt_only2 = usr_slot_only2;
      placed_nxt_o = 1'b1;
      // slot-restricted work is pushed out to slot 2 of the bundle
      if (usr_slot_only2)
        nxt_slot = `UED_SLOT_RESTRICT;
      // a group-leading one opens a fresh group
      nxt_fig = first_ff | usr_lead;
      nxt_first = usr_end;
      if (!usr_slot_only2 && !usr_end)
        nxt_first = 1'b0;
    end
    // slot advances after each issue, wrapping past slot 2
    if (vld_ff)
      nxt_slot = (slot_ff == `UED_SLOT_RESTRICT) ? '0 : slot_ff + 2'h1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      slot_ff <= '0;
      first_ff <= 1'b1;
      vld_ff <= 1'b0;
      insn_ff <= `UED_ZERO_FIELD;
      zm_ff <= `UED_ZERO_FIELD;
      im_ff <= `UED_ZERO_FIELD;
      cls_ff <= UED_CLS_DEFINED;
      lead_ff <= 1'b0;
      end_ff <= 1'b0;
      only2_ff <= 1'b0;
      fig_ff <= 1'b0;
      pr_ff <= '0;
      usr_placed_ff <= 1'b0;
      usr_fault_ff <= 1'b0;
      usr_fault_slot_ff <= '0;
    end
    else
    begin
      slot_ff <= nxt_slot;
      first_ff <= nxt_first;
      vld_ff <= nxt_vld;
      insn_ff <= nxt_insn;
      zm_ff <= nxt_zm;
      im_ff <= nxt_im;
      cls_ff <= nxt_cls;
      lead_ff <= nxt_lead;
      end_ff <= nxt_end;
      only2_ff <= nxt_only2;
      fig_ff <= nxt_fig;
      pr_ff <= nxt_pr;
      usr_placed_ff <= placed_nxt_o;
      usr_fault_ff <= lnk.fault_req;
      usr_fault_slot_ff <= lnk.fault_slot;
    end
  end

  assign lnk.issue_valid = vld_ff;
  assign lnk.issue_insn = insn_ff;
  assign lnk.issue_zero_mask = zm_ff;
  assign lnk.issue_ign_mask = im_ff;
  assign lnk.issue_class = cls_ff;
  assign lnk.issue_lead = lead_ff;
  assign lnk.issue_end = end_ff;
  assign lnk.issue_slot_only2 = only2_ff;
  assign lnk.issue_slot = only2_ff ? `UED_SLOT_RESTRICT : slot_ff;
  assign lnk.issue_first_in_group = fig_ff;
  assign lnk.issue_last_in_group = end_ff;
  assign lnk.predicate_register_file = pr_ff;
endmodule : ued_issue
`default_nettype wire

// >>> shared/ued_link_if.sv
// ued_link_if.sv: issue-to-decode link between instruction issue and the decoder
// assumes: one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
`include "ued_regs.svh"
interface ued_link_if
  import ued_pkg::*;
  ();
  logic issue_valid;
  logic [`UED_INSN_W-1:0] issue_insn;
  logic [`UED_INSN_W-1:0] issue_zero_mask;
  logic [`UED_INSN_W-1:0] issue_ign_mask;
  ued_class_t issue_class;
  logic issue_lead;
  logic issue_end;
  logic issue_slot_only2;
  logic [`UED_SLOT_W-1:0] issue_slot;
  logic issue_first_in_group;
  logic issue_last_in_group;
  logic [`UED_NPRED-1:0] predicate_register_file;
  logic dec_valid;
  ued_action_t dec_action;
  logic [`UED_INSN_W-1:0] dec_insn;
  logic fault_req;
  logic [`UED_SLOT_W-1:0] fault_slot;
  modport issuer (
    output issue_valid, issue_insn, issue_zero_mask, issue_ign_mask, issue_class,
    output issue_lead, issue_end, issue_slot_only2, issue_slot,
    output issue_first_in_group, issue_last_in_group, predicate_register_file,
    input dec_valid, dec_action, dec_insn, fault_req, fault_slot
  );
  modport decoder (
    input issue_valid, issue_insn, issue_zero_mask, issue_ign_mask, issue_class,
    input issue_lead, issue_end, issue_slot_only2, issue_slot,
    input issue_first_in_group, issue_last_in_group, predicate_register_file,
    output dec_valid, dec_action, dec_insn, fault_req, fault_slot
  );
endinterface : ued_link_if
`default_nettype wire

// >>> shared/ued_pkg.sv
// ued_pkg.sv: types shared by the issue end and the decode end
// assumes: ued_regs.svh on the include path
`include "ued_regs.svh"
package ued_pkg;
  // class of an encoding, as known from the opcode extension tables
  typedef enum logic [1:0] {
    UED_CLS_DEFINED,
    UED_CLS_IGNORED,
    UED_CLS_RESERVED,
    UED_CLS_RSV_IF_PRED
  } ued_class_t;
  // how a decoded instruction proceeds
  typedef enum logic [1:0] {
    UED_ACT_NONE,
    UED_ACT_EXEC,
    UED_ACT_NOP,
    UED_ACT_FAULT
  } ued_action_t;
endpackage : ued_pkg

// >>> shared/ued_regs.svh
// ued_regs.svh: field positions, widths and constants for the unused-encoding decode policy
// assumes: 41-bit instruction words, three slots per bundle, 64 predicate registers
`ifndef UED_REGS_SVH
`define UED_REGS_SVH
`define UED_INSN_W 41
`define UED_QP_HI 5
`define UED_QP_LO 0
`define UED_QP_W 6
`define UED_NPRED 64
`define UED_SLOT_W 2
`define UED_SLOT_RESTRICT 2'h2
`define UED_ZERO_FIELD 41'h000_0000_0000
`define UED_PRED_P0 6'h00
`endif

// >>> sim/ued_monitor.sv
// ued_monitor.sv: link checker for the decode policy
// assumes: link signals wired in by name, one clock
`timescale 1ns/10ps
`default_nettype none
`include "ued_regs.svh"
module ued_monitor
  import ued_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // issue side
  input wire logic issue_valid,
  input wire logic [`UED_INSN_W-1:0] issue_insn,
  input wire logic [`UED_INSN_W-1:0] issue_ign_mask,
  input wire ued_class_t issue_class,
  input wire logic issue_slot_only2,
  input wire logic [`UED_SLOT_W-1:0] issue_slot,
  input wire logic [`UED_NPRED-1:0] predicate_register_file,
  // decode side
  input wire logic dec_valid,
  input wire ued_action_t dec_action,
  input wire logic [`UED_INSN_W-1:0] dec_insn,
  input wire logic fault_req,
  input wire logic [`UED_SLOT_W-1:0] fault_slot
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic pq;
  logic iv;
  // predicate 0 always reads true
  assign pq = predicate_register_file[issue_insn[`UED_QP_HI:`UED_QP_LO]]
              | (issue_insn[`UED_QP_HI:`UED_QP_LO] == `UED_PRED_P0);
  assign iv = issue_valid;
  property p_lat; iv |=> dec_valid; endproperty
  a_lat: assert property (p_lat) else $error("no decode after issue");
  property p_quiet; !iv |=> !dec_valid && !fault_req; endproperty
  a_quiet: assert property (p_quiet) else $error("decode without issue");
  property p_ign; iv && issue_class == UED_CLS_IGNORED |=> dec_action == UED_ACT_NOP && !fault_req;
  endproperty
  a_ign: assert property (p_ign) else $error("ignored class not nop");
  property p_rsv; iv && issue_class == UED_CLS_RESERVED |=> fault_req && fault_slot == $past(issue_slot);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved class no fault");
  property p_rp1; iv && issue_class == UED_CLS_RSV_IF_PRED && pq |=> fault_req; endproperty
  a_rp1: assert property (p_rp1) else $error("predicated reserved no fault");
  property p_rp0; iv && issue_class == UED_CLS_RSV_IF_PRED && !pq |=> dec_action == UED_ACT_NOP;
  endproperty
  a_rp0: assert property (p_rp0) else $error("predicated reserved not nop");
  property p_def; iv && issue_class == UED_CLS_DEFINED |=> dec_action == UED_ACT_EXEC && !fault_req;
  endproperty
  a_def: assert property (p_def) else $error("defined class not executed");
  property p_insn; iv |=> dec_insn == $past(issue_insn); endproperty
  a_insn: assert property (p_insn) else $error("decoded word differs");
  property p_igf; iv |-> (issue_insn & issue_ign_mask) == '0; endproperty
  a_igf: assert property (p_igf) else $error("ignored bits not cleared");
  property p_only2; iv && issue_slot_only2 |-> issue_slot == `UED_SLOT_RESTRICT; endproperty
  a_only2: assert property (p_only2) else $error("restricted slot not 2");
  c_rsv: cover property (iv && issue_class == UED_CLS_RESERVED);
  c_rp0: cover property (iv && issue_class == UED_CLS_RSV_IF_PRED && !pq);
  c_ign: cover property (iv && issue_class == UED_CLS_IGNORED);
endmodule : ued_monitor
`default_nettype wire

// >>> sim/unused_encoding_decode_policy_tb.sv
// unused_encoding_decode_policy_tb.sv: issue end joined to decode end, model compare
// assumes: answer two edges after the offer, one offer a cycle
`timescale 1ns/10ps
`default_nettype none
`include "ued_regs.svh"
module unused_encoding_decode_policy_tb
  import ued_pkg::*;
;
  logic clock, rstn, v, o2, pl, uf, pf, x_vld, x_flt, ld, en, pe;
  logic [`UED_INSN_W-1:0] ins, zm, im, x_ins;
  logic [`UED_NPRED-1:0] prd;
  logic [1:0] ufs, ps, x_slot;
  ued_class_t cls;
  ued_action_t x_act;
  int err_count, n_tests, seed, cyc, k, sl;
  int q_t[$];
  logic [45:0] q_v[$];
  ued_link_if lnk ();
  ued_issue u_ued_issue (.clock(clock), .rstn(rstn), .usr_valid(v), .usr_insn(ins),
    .usr_zero_mask(zm), .usr_ign_mask(im), .usr_class(cls), .usr_lead(ld), .usr_end(en),
    .usr_slot_only2(o2), .usr_preds(prd), .usr_placed_ff(pl), .usr_fault_ff(uf),
    .usr_fault_slot_ff(ufs), .lnk(lnk.issuer));
  ued_decode u_ued_decode (.clock(clock), .rstn(rstn), .lnk(lnk.decoder), .exe_valid_ff(x_vld),
    .exe_action_ff(x_act), .exe_insn_ff(x_ins), .exc_fault_ff(x_flt), .exc_slot_ff(x_slot),
    .exc_place_err_ff(pe));
  ued_monitor u_mon (.clock(clock), .rstn(rstn), .issue_valid(lnk.issue_valid),
    .issue_insn(lnk.issue_insn), .issue_ign_mask(lnk.issue_ign_mask),
    .issue_class(lnk.issue_class), .issue_slot_only2(lnk.issue_slot_only2),
    .issue_slot(lnk.issue_slot), .predicate_register_file(lnk.predicate_register_file),
    .dec_valid(lnk.dec_valid), .dec_action(lnk.dec_action), .dec_insn(lnk.dec_insn),
    .fault_req(lnk.fault_req), .fault_slot(lnk.fault_slot));
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want)
    begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : chk
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // one negedge: check what is due, then offer the next word
  task automatic step(input logic vv, input ued_class_t cc, input logic oo);
    logic pt;
    logic [45:0] e;
    ued_action_t a;
    chk(pl, v);
    chk(pe, 1'b0);
    chk({uf, ufs}, {pf, ps});
    pf = x_flt;
    ps = x_slot;
    if (q_t.size() > 0 && q_t[0] == cyc)
    begin
      e = q_v.pop_front();
      void'(q_t.pop_front());
      chk({x_vld, x_act, x_flt, x_ins}, {1'b1, e[45:43], e[40:0]});
      if (e[43])
        chk(x_slot, e[42:41]);
    end
    else
      chk({x_vld, x_flt}, 2'h0);
    v = vv;
    cls = cc;
    o2 = oo;
    ld = 1'($random(seed));
    en = 1'($random(seed));
    ins = 41'({$random(seed), $random(seed)});
    zm = 41'({$random(seed), $random(seed)}) & ~41'h3F;
    im = 41'({$random(seed), $random(seed)}) & ~41'h3F;
    prd = {$random(seed), $random(seed)};
    if (vv)
    begin
      pt = prd[ins[5:0]] | (ins[5:0] == 6'h00);
      a = cc == UED_CLS_DEFINED ? UED_ACT_EXEC : cc == UED_CLS_IGNORED ? UED_ACT_NOP :
        (cc == UED_CLS_RESERVED || pt) ? UED_ACT_FAULT : UED_ACT_NOP;
      q_v.push_back({a, a == UED_ACT_FAULT, oo ? 2'h2 : 2'(sl), ins & ~(zm | im)});
      q_t.push_back(cyc + 2);
      sl = sl == 2 ? 0 : sl + 1;
    end
    cyc++;
  endtask : step
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // limit well past the 803 cycles of traffic
  initial
  begin
    #(25 * 2000);
    err_count++;
    give_verdict();
  end
  initial
  begin
    seed = 39302;
    {v, o2, pf, ps, rstn, ld, en} = '0;
    {ins, zm, im, prd} = '0;
    cls = UED_CLS_DEFINED;
    {err_count, n_tests, cyc, sl} = '0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    for (k = 0; k < 803; k++)
    begin
      @(negedge clock);
      step(k < 800 && ($random(seed) & 3) != 0, ued_class_t'($random(seed) & 3), k == 799);
    end
    give_verdict();
  end
endmodule : unused_encoding_decode_policy_tb
`default_nettype wire
